// File: hdl/icu_params.svh
// What this block does
// RL1 - Three nesting levels exist (highest, high, low); vectors 0 and 1 may be highest or low, all others high or low.
// RL2 - While a level is in service, no request at that level or below is accepted, so only higher levels nest.
// RL3 - Among requests to different vectors pending together, the one at the highest level wins.
// RL4 - Among pending requests at the same level, the smallest vector address wins.
// RL5 - Forty sources fold onto ten vectors at 00003H plus eight per step up to 0004BH.
// RL6 - Pins two and four, timer-zero low byte, host-port bus active and infrared receive share vector 00013H.
// RL7 - Timer-zero high byte, pin six and host-port connect, disconnect and resume share vector 00023H.
// RL8 - Halt standby ends on reset or on any request that can be accepted.
// RL9 - Hold standby ends on reset pin low, a wake pin at its set level, a port-zero or a bus-active request.
// RL10 - Crystal hold also ends on a base-timer or an infrared receive request.
// RL11 - Each source request stays pending until it is serviced, so a blocked request is granted later.
// RL12 - The CPU signals end of service so the previous in-service level is restored.
`ifndef ICU_PARAMS_SVH
`define ICU_PARAMS_SVH

`define ICU_NUM_SRC      40
`define ICU_NUM_VEC      10
`define ICU_NUM_WPIN     5
`define ICU_VEC_BASE     20'h00003
`define ICU_VEC_STEP     20'h00008
`define ICU_VEC_LAST     20'h0004b
// First source of each vector; the last entry closes vector 9
`define ICU_VEC_BOUNDS   '{0, 1, 2, 7, 10, 15, 20, 22, 26, 33, 40}
`define ICU_VEC_SHARED_A 2
`define ICU_VEC_SHARED_B 4
`define ICU_NUM_TOP_VEC  2
// Source positions inside the request vector
`define ICU_SRC_PIN_TWO   2
`define ICU_SRC_TIMER_ZERO_LOW_EVENT  3
`define ICU_SRC_PIN_FOUR  4
`define ICU_SRC_BUS_ACT   5
`define ICU_SRC_IR_RX     6
`define ICU_SRC_BASE_TMR  9
`define ICU_SRC_TIMER_ZERO_HIGH_EVENT 10
`define ICU_SRC_PIN_SIX   11
`define ICU_SRC_CONNECT   12
`define ICU_SRC_DISCON    13
`define ICU_SRC_RESUME    14
`define ICU_SRC_PORT0     33
`define ICU_INS_RESET     3'h0

`endif

// File: hdl/icu_pkg.sv
package icu_pkg;

  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_LOW  = 2'b01,
    LVL_HIGH = 2'b10,
    LVL_TOP  = 2'b11
  } icu_lvl_type;

  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_HALT  = 2'b01,
    MODE_HOLD  = 2'b10,
    MODE_XHOLD = 2'b11
  } icu_mode_type;

  typedef struct packed {
    logic        valid;
    logic [3:0]  vec_idx;
    icu_lvl_type level;
    logic [19:0] vec_addr;
  } icu_irq_type;

endpackage

// File: hdl/icu_vec_slot.sv
`timescale 1ns/1ps
`default_nettype none
`include "icu_params.svh"

module icu_vec_slot #(
  parameter int FIRST = 0,
  parameter int COUNT = 1
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_b,
  // Requests and service
  input  wire logic [`ICU_NUM_SRC-1:0]  src_evt,
  input  wire logic                     serviced,
  output logic                          pend
);

  logic [COUNT-1:0] pend_reg;
  logic [COUNT-1:0] pend_next;
  wire  [COUNT-1:0] evt_slice  = src_evt[FIRST +: COUNT];
  // Lowest pending source is the one retired by a service
  wire  [COUNT-1:0] lowest_one = pend_reg & (~pend_reg + COUNT'(1));

  // A new event in the retiring cycle is kept: set wins over clear
  assign pend_next = (pend_reg & ~(serviced ? lowest_one : '0)) | evt_slice; // RL11
  assign pend      = |pend_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= pend_next;
    end
  end

endmodule // icu_vec_slot
`default_nettype wire

// File: hdl/icu_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "icu_params.svh"

module icu_top (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  // Source requests from on-chip trigger logic
  input  wire logic [`ICU_NUM_SRC-1:0]   src_evt,
  input  wire logic [`ICU_NUM_VEC-1:0]   vec_lvl_sel,
  // CPU core
  output icu_pkg::icu_irq_type           irq_out_reg,
  input  wire logic                      irq_ack,
  input  wire logic                      irq_eoi,
  output logic [2:0]                     ins_mask_reg,
  // Standby control
  input  wire logic                      stby_cmd_vld,
  input  wire icu_pkg::icu_mode_type     stby_cmd,
  output icu_pkg::icu_mode_type          stby_mode_reg,
  output logic                           wake_reg,
  // Wake pins
  input  wire logic                      res_pin_b,
  input  wire logic [`ICU_NUM_WPIN-1:0]  wake_pin,
  input  wire logic [`ICU_NUM_WPIN-1:0]  wake_pin_pol
);

  localparam int BOUNDS [0:`ICU_NUM_VEC] = `ICU_VEC_BOUNDS;

  // ************************************************
  // Source pending per vector
  // ************************************************
  logic [`ICU_NUM_VEC-1:0] vec_pend;
  logic [`ICU_NUM_VEC-1:0] vec_serviced;

  genvar gv;
  generate
    for (gv = 0; gv < `ICU_NUM_VEC; gv++) begin : g_slot
      assign vec_serviced[gv] = irq_ack && irq_out_reg.valid && (irq_out_reg.vec_idx == 4'(gv));
      icu_vec_slot #(
        .FIRST (BOUNDS[gv]),
        .COUNT (BOUNDS[gv+1] - BOUNDS[gv])
      ) u_slot (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .src_evt  (src_evt),
        .serviced (vec_serviced[gv]),
        .pend     (vec_pend[gv])
      ); // RL5 RL6 RL7 RL11
    end
  endgenerate

  // ************************************************
  // Level per vector and arbitration
  // ************************************************
  icu_pkg::icu_lvl_type vec_lvl [0:`ICU_NUM_VEC-1];
  logic [`ICU_NUM_VEC-1:0] hit_mask;
  icu_pkg::icu_lvl_type best_lvl;
  logic [3:0]           best_idx;
  icu_pkg::icu_lvl_type cur_lvl;
  logic                 cand_valid;

  generate
    for (gv = 0; gv < `ICU_NUM_VEC; gv++) begin : g_lvl
      // Pin vectors choose highest or low, the rest high or low
      assign vec_lvl[gv] = !vec_pend[gv] ? icu_pkg::LVL_NONE :
                           !vec_lvl_sel[gv] ? icu_pkg::LVL_LOW :
                           (gv < `ICU_NUM_TOP_VEC) ? icu_pkg::LVL_TOP : icu_pkg::LVL_HIGH; // RL1
      assign hit_mask[gv] = vec_pend[gv] && (vec_lvl[gv] == best_lvl);
    end
  endgenerate

  // Walking downward with >= lets the smallest address win a level tie
  always_comb begin
    best_lvl = icu_pkg::LVL_NONE;
    best_idx = 4'h0;
    for (int v = `ICU_NUM_VEC - 1; v >= 0; v--) begin
      if (vec_pend[v] && (vec_lvl[v] >= best_lvl)) begin // RL3 RL4
        best_lvl = vec_lvl[v];
        best_idx = 4'(v);
      end
    end
  end

  assign cur_lvl = ins_mask_reg[2] ? icu_pkg::LVL_TOP :
                   ins_mask_reg[1] ? icu_pkg::LVL_HIGH :
                   ins_mask_reg[0] ? icu_pkg::LVL_LOW : icu_pkg::LVL_NONE;
  // Equal or lower levels stay pending until service ends
  assign cand_valid = (best_lvl != icu_pkg::LVL_NONE) && (best_lvl > cur_lvl); // RL2

  // ************************************************
  // Request to the CPU and in-service levels
  // ************************************************
  icu_pkg::icu_irq_type irq_next;
  logic [2:0]           ins_pop;
  logic [2:0]           ins_push;
  logic [2:0]           ins_next;
  wire                  take = irq_ack && irq_out_reg.valid;

  // Request drops for a cycle after a take, so a stale vector is never shown
  assign irq_next.valid    = cand_valid && !take;
  assign irq_next.vec_idx  = best_idx;
  assign irq_next.level    = best_lvl;
  assign irq_next.vec_addr = `ICU_VEC_BASE + (`ICU_VEC_STEP * 20'(best_idx)); // RL5

  // End of service retires the highest level in service
  assign ins_pop  = !irq_eoi ? 3'h0 :
                    ins_mask_reg[2] ? 3'h4 :
                    ins_mask_reg[1] ? 3'h2 :
                    ins_mask_reg[0] ? 3'h1 : 3'h0; // RL12
  assign ins_push = take ? (3'h1 << (irq_out_reg.level - 2'h1)) : 3'h0;
  assign ins_next = (ins_mask_reg & ~ins_pop) | ins_push;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_out_reg  <= '0;
      ins_mask_reg <= `ICU_INS_RESET;
    end else begin
      irq_out_reg  <= irq_next;
      ins_mask_reg <= ins_next;
    end
  end

  // ************************************************
  // Wake pin synchroniser
  // ************************************************
  logic [`ICU_NUM_WPIN:0] pin_s1_reg;
  logic [`ICU_NUM_WPIN:0] pin_s2_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      pin_s1_reg <= {res_pin_b, wake_pin};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // ************************************************
  // Standby modes
  // ************************************************
  wire pin_wake  = |(~(pin_s2_reg[`ICU_NUM_WPIN-1:0] ^ wake_pin_pol));
  // Reset pin synchroniser starts at zero, so ignore it right after reset
  logic res_seen_reg;
  wire hold_wake  = (res_seen_reg && !pin_s2_reg[`ICU_NUM_WPIN]) || pin_wake ||
                    src_evt[`ICU_SRC_PORT0] || src_evt[`ICU_SRC_BUS_ACT]; // RL9
  wire xhold_wake = hold_wake || src_evt[`ICU_SRC_BASE_TMR] || src_evt[`ICU_SRC_IR_RX]; // RL10

  icu_pkg::icu_mode_type mode_next;

  always_comb begin
    mode_next = stby_mode_reg;
    case (stby_mode_reg)
      icu_pkg::MODE_RUN: begin
        if (stby_cmd_vld) begin
          mode_next = stby_cmd;
        end
      end
      icu_pkg::MODE_HALT: begin
        if (cand_valid) begin // RL8
          mode_next = icu_pkg::MODE_RUN;
        end
      end
      icu_pkg::MODE_HOLD: begin
        if (hold_wake) begin // RL9
          mode_next = icu_pkg::MODE_RUN;
        end
      end
      icu_pkg::MODE_XHOLD: begin
        if (xhold_wake) begin // RL10
          mode_next = icu_pkg::MODE_RUN;
        end
      end
      default: begin
        mode_next = icu_pkg::MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stby_mode_reg <= icu_pkg::MODE_RUN;
      wake_reg      <= 1'b0;
      res_seen_reg  <= 1'b0;
    end else begin
      stby_mode_reg <= mode_next;
      wake_reg      <= (stby_mode_reg != icu_pkg::MODE_RUN) && (mode_next == icu_pkg::MODE_RUN);
      res_seen_reg  <= res_seen_reg | pin_s2_reg[`ICU_NUM_WPIN];
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_take;
    irq_ack && irq_out_reg.valid;
  endsequence

  sequence s_req_gone;
    !irq_out_reg.valid;
  endsequence

  AST_LVL_MAP: assert property ( // RL1
    irq_out_reg.valid && (irq_out_reg.vec_idx >= 4'h2) |-> irq_out_reg.level != icu_pkg::LVL_TOP)
    else $error("top level granted to a non-pin vector");

  AST_NEST_ONLY_HIGHER: assert property ( // RL2
    irq_out_reg.valid |-> !$past(ins_mask_reg[2]) &&
                          ((irq_out_reg.level == icu_pkg::LVL_TOP) || !$past(ins_mask_reg[1])) &&
                          ((irq_out_reg.level != icu_pkg::LVL_LOW) || !$past(ins_mask_reg[0])))
    else $error("request not above the in-service level");

  AST_HIGHEST_WINS: assert property ( // RL3
    irq_out_reg.valid |-> (irq_out_reg.level == icu_pkg::LVL_TOP) ||
                          (($past(vec_pend[1:0] & vec_lvl_sel[1:0]) == 2'h0) &&
                           ((irq_out_reg.level == icu_pkg::LVL_HIGH) || ($past(vec_pend & vec_lvl_sel) == 10'h0))))
    else $error("granted level is not the highest pending");

  AST_SMALLEST_ADDR: assert property ( // RL4
    irq_out_reg.valid |-> ($past(hit_mask) & ((10'h1 << irq_out_reg.vec_idx) - 10'h1)) == 10'h0)
    else $error("smaller vector at same level was passed over");

  AST_VEC_ADDR: assert property ( // RL5
    irq_out_reg.valid |-> (irq_out_reg.vec_addr == `ICU_VEC_BASE + `ICU_VEC_STEP * 20'(irq_out_reg.vec_idx))
                          && (irq_out_reg.vec_addr <= `ICU_VEC_LAST))
    else $error("vector address out of step");

  AST_SHARED_A: assert property ( // RL6
    src_evt[`ICU_SRC_BUS_ACT] || src_evt[`ICU_SRC_IR_RX] || src_evt[`ICU_SRC_TIMER_ZERO_LOW_EVENT]
    |=> vec_pend[`ICU_VEC_SHARED_A])
    else $error("shared source missed vector 00013H");

  AST_SHARED_B: assert property ( // RL7
    src_evt[`ICU_SRC_CONNECT] || src_evt[`ICU_SRC_RESUME] || src_evt[`ICU_SRC_TIMER_ZERO_HIGH_EVENT]
    |=> vec_pend[`ICU_VEC_SHARED_B])
    else $error("shared source missed vector 00023H");

  AST_HALT_EXIT: assert property ( // RL8
    (stby_mode_reg == icu_pkg::MODE_HALT) && cand_valid |=> (stby_mode_reg == icu_pkg::MODE_RUN) && wake_reg)
    else $error("halt not left on an acceptable request");

  AST_HOLD_EXIT: assert property ( // RL9
    (stby_mode_reg == icu_pkg::MODE_HOLD) && src_evt[`ICU_SRC_PORT0] |=> stby_mode_reg == icu_pkg::MODE_RUN)
    else $error("hold not left on port-zero request");

  AST_XHOLD_EXIT: assert property ( // RL10
    (stby_mode_reg == icu_pkg::MODE_XHOLD) && src_evt[`ICU_SRC_BASE_TMR] |=> stby_mode_reg == icu_pkg::MODE_RUN)
    else $error("crystal hold not left on base-timer request");

  AST_PEND_HELD: assert property ( // RL11
    vec_pend[`ICU_VEC_SHARED_A] && !vec_serviced[`ICU_VEC_SHARED_A] |=> vec_pend[`ICU_VEC_SHARED_A])
    else $error("pending request lost without service");

  AST_TAKE_NESTS: assert property ( // RL2
    s_take ##0 (irq_out_reg.level == icu_pkg::LVL_HIGH) |=> s_req_gone ##0 ins_mask_reg[1])
    else $error("take did not record the level in service");

  AST_EOI_POP: assert property ( // RL12
    irq_eoi && !irq_ack && ins_mask_reg[2] |=> !ins_mask_reg[2] && (ins_mask_reg[1:0] == $past(ins_mask_reg[1:0])))
    else $error("end of service did not restore prior level");

endmodule // icu_top
`default_nettype wire

// File: tb/icu_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// CPU core stand-in
// ****
module icu_cpu_model (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  // Unit side
  input  wire icu_pkg::icu_irq_type irq,
  output logic                      irq_ack,
  output logic                      irq_eoi,
  // Bench side
  input  wire logic                 ack_en,
  input  wire logic [3:0]           ack_dly,
  input  wire logic                 eoi_req,
  output icu_pkg::icu_irq_type      taken,
  output logic                      taken_stb
);
  logic [3:0] wait_reg;

  // A slow answer lets the unit swap in a better vector while we wait
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      {irq_ack, irq_eoi, taken_stb, wait_reg} <= '0;
      taken <= '0;
    end else begin
      irq_eoi   <= eoi_req;
      taken_stb <= irq_ack & irq.valid;
      if (irq_ack) taken <= irq;
      if (irq_ack || !irq.valid || !ack_en) begin
        irq_ack  <= 1'h0;
        wait_reg <= 4'h0;
      end else if (wait_reg == ack_dly) irq_ack <= 1'h1;
      else wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule // icu_cpu_model
`default_nettype wire

// File: tb/three_level_vectored_interrupt_unit_bench.sv
`timescale 1ns/1ps
`default_nettype none
module three_level_vectored_interrupt_unit_bench;
  logic                  sys_clk, rst_b, irq_ack, irq_eoi, stby_cmd_vld, wake_reg;
  logic                  res_pin_b, ack_en, eoi_req, taken_stb;
  logic [3:0]            ack_dly;
  logic [39:0]           src_evt;
  logic [9:0]            vec_lvl_sel;
  logic [2:0]            ins_mask_reg;
  logic [4:0]            wake_pin, wake_pin_pol;
  icu_pkg::icu_irq_type  irq_out_reg, taken;
  icu_pkg::icu_mode_type stby_cmd, stby_mode_reg;
  int                    error_cnt, total_checks;

  icu_top icu_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .src_evt(src_evt), .vec_lvl_sel(vec_lvl_sel),
    .irq_out_reg(irq_out_reg), .irq_ack(irq_ack), .irq_eoi(irq_eoi), .ins_mask_reg(ins_mask_reg),
    .stby_cmd_vld(stby_cmd_vld), .stby_cmd(stby_cmd), .stby_mode_reg(stby_mode_reg), .wake_reg(wake_reg),
    .res_pin_b(res_pin_b), .wake_pin(wake_pin), .wake_pin_pol(wake_pin_pol));
  icu_cpu_model icu_cpu_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .irq(irq_out_reg), .irq_ack(irq_ack),
    .irq_eoi(irq_eoi), .ack_en(ack_en), .ack_dly(ack_dly), .eoi_req(eoi_req), .taken(taken),
    .taken_stb(taken_stb));

  // ****
  // Helpers
  // ****
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  task automatic hang;
    check(32'h0, 32'h1);
    give_verdict();
  endtask

  function automatic icu_pkg::icu_lvl_type lvl_of(input int v);
    if (!vec_lvl_sel[v]) return icu_pkg::LVL_LOW;
    return (v < 2) ? icu_pkg::LVL_TOP : icu_pkg::LVL_HIGH;
  endfunction

  function automatic int vec_of(input int b);
    int lim[10] = '{1, 2, 7, 10, 15, 20, 22, 26, 33, 40};
    for (int v = 0; v < 10; v++) begin
      if (b < lim[v]) return v;
    end
    return -1;
  endfunction

  task automatic pulse(input logic [39:0] m);
    @(posedge sys_clk) src_evt <= m;
    @(posedge sys_clk) src_evt <= 40'h0;
  endtask

  // Waits for the CPU stand-in to take a vector, then checks what it got
  task automatic take_chk(input int v, input logic [2:0] m);
    int n;
    n = 0;
    @(posedge sys_clk) ack_en <= 1'h1;
    do begin
      @(negedge sys_clk);
      n++;
      if (n > 40) hang();
    end while (taken_stb !== 1'h1);
    check(taken.vec_idx, v);
    check(taken.vec_addr, 32'h3 + 32'h8 * v);
    check(taken.level, lvl_of(v));
    check(ins_mask_reg, m);
  endtask

  task automatic eoi_do(input logic [2:0] m);
    @(posedge sys_clk) eoi_req <= 1'h1;
    @(posedge sys_clk) eoi_req <= 1'h0;
    repeat (2) @(negedge sys_clk);
    check(ins_mask_reg, m);
  endtask

  task automatic stby(input icu_pkg::icu_mode_type m);
    @(posedge sys_clk) begin
      stby_cmd_vld <= 1'h1;
      stby_cmd     <= m;
    end
    @(posedge sys_clk) stby_cmd_vld <= 1'h0;
    @(negedge sys_clk);
    check(stby_mode_reg, m);
  endtask

  task automatic wait_wake;
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (n > 12) hang();
    end while (wake_reg !== 1'h1);
    check(stby_mode_reg, icu_pkg::MODE_RUN);
    @(negedge sys_clk);
    check(wake_reg, 1'h0);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_map;
    int bits[20] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 10, 11, 12, 13, 14, 15, 20, 22, 26, 33, 39};
    foreach (bits[i]) begin
      pulse(40'h1 << bits[i]);
      take_chk(vec_of(bits[i]), 3'h1);
      eoi_do(3'h0);
    end
    $display("test map done");
  endtask

  // All pending at once; bit 2 and bit 6 share a vector, so it is taken twice
  task automatic t_prio;
    int         vs[6] = '{1, 6, 8, 9, 2, 2};
    logic [2:0] ms[6] = '{3'h4, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1};
    @(posedge sys_clk) begin
      vec_lvl_sel <= 10'h342;
      ack_dly     <= 4'h5;
    end
    pulse(40'h80_0410_0046);
    foreach (vs[k]) begin
      take_chk(vs[k], ms[k]);
      eoi_do(3'h0);
    end
    @(posedge sys_clk) ack_dly <= 4'h0;
    $display("test prio done");
  endtask

  task automatic t_nest;
    @(posedge sys_clk) vec_lvl_sel <= 10'h004;
    pulse(40'h1);
    take_chk(0, 3'h1);
    pulse(40'h80);
    repeat (6) begin
      @(negedge sys_clk);
      check(irq_out_reg.valid, 1'h0);
    end
    pulse(40'h4);
    take_chk(2, 3'h3);
    eoi_do(3'h1);
    check(irq_out_reg.valid, 1'h0);
    eoi_do(3'h0);
    take_chk(3, 3'h1);
    eoi_do(3'h0);
    $display("test nest done");
  endtask

  task automatic t_stby;
    logic [39:0] sm[4] = '{40'h2_0000_0000, 40'h20, 40'h200, 40'h40};
    int          sv[4] = '{9, 2, 3, 2};
    @(posedge sys_clk) begin
      vec_lvl_sel <= 10'h000;
      ack_en      <= 1'h0;
    end
    stby(icu_pkg::MODE_HALT);
    pulse(40'h2);
    wait_wake();
    take_chk(1, 3'h1);
    eoi_do(3'h0);
    @(posedge sys_clk) ack_en <= 1'h0;
    stby(icu_pkg::MODE_HOLD);
    pulse(40'h200);
    // A command outside run must be ignored
    @(posedge sys_clk) begin
      stby_cmd_vld <= 1'h1;
      stby_cmd     <= icu_pkg::MODE_HALT;
    end
    @(posedge sys_clk) stby_cmd_vld <= 1'h0;
    repeat (6) @(negedge sys_clk);
    check(stby_mode_reg, icu_pkg::MODE_HOLD);
    @(posedge sys_clk) res_pin_b <= 1'h0;
    wait_wake();
    @(posedge sys_clk) res_pin_b <= 1'h1;
    take_chk(3, 3'h1);
    eoi_do(3'h0);
    @(posedge sys_clk) ack_en <= 1'h0;
    // Low wake levels are tried too; the pin synchronisers drain before each entry
    for (int k = 0; k < 10; k++) begin
      @(posedge sys_clk) begin
        wake_pin_pol <= (k < 5) ? 5'h1f : 5'h00;
        wake_pin     <= (k < 5) ? 5'h00 : 5'h1f;
      end
      repeat (3) @(posedge sys_clk);
      stby(icu_pkg::MODE_HOLD);
      @(posedge sys_clk) wake_pin <= wake_pin ^ (5'h1 << (k % 5));
      wait_wake();
    end
    @(posedge sys_clk) begin
      wake_pin_pol <= 5'h1f;
      wake_pin     <= 5'h00;
    end
    repeat (3) @(posedge sys_clk);
    foreach (sm[k]) begin
      stby((k < 2) ? icu_pkg::MODE_HOLD : icu_pkg::MODE_XHOLD);
      pulse(sm[k]);
      wait_wake();
      take_chk(sv[k], 3'h1);
      eoi_do(3'h0);
      @(posedge sys_clk) ack_en <= 1'h0;
    end
    $display("test stby done");
  endtask

  // Reset in mid-service must drop the in-service level and every pending source
  task automatic t_rst;
    pulse(40'h400_0000);
    take_chk(8, 3'h1);
    pulse(40'h80_0000_0000);
    @(posedge sys_clk) rst_b <= 1'h0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (6) begin
      @(negedge sys_clk);
      check({irq_out_reg.valid, ins_mask_reg, stby_mode_reg}, 32'h0);
    end
    pulse(40'h1);
    take_chk(0, 3'h1);
    eoi_do(3'h0);
    $display("test reset done");
  endtask

  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    {rst_b, stby_cmd_vld, ack_en, eoi_req, wake_pin, ack_dly} = '0;
    {res_pin_b, wake_pin_pol} = 6'h3f;
    src_evt = 40'h0;
    vec_lvl_sel = 10'h000;
    stby_cmd = icu_pkg::MODE_RUN;
    error_cnt = 0;
    total_checks = 0;
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'h1;
    @(negedge sys_clk);
    check(irq_out_reg, 32'h0);
    check(stby_mode_reg, icu_pkg::MODE_RUN);
    t_map();
    t_prio();
    t_nest();
    t_stby();
    t_rst();
    give_verdict();
  end
endmodule // three_level_vectored_interrupt_unit_bench
`default_nettype wire
